// >>> core/fwe_defines.svh
// Constants for the write enable and buffer program command slice.
// Assumes a byte-wide serial opcode, 24-bit address and 256-byte page buffer.
`ifndef FWE_DEFINES_SVH
`define FWE_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Opcodes
`define FWE_OP_WRITE_ENABLE   8'h06
`define FWE_OP_WRITE_DISABLE  8'h04
`define FWE_OP_VOLATILE_EN    8'h50
`define FWE_OP_BUFFER_PROGRAM 8'h88
`define FWE_OP_STATUS_WRITE   8'h01

////////////////////////////////////////////////////////////////////////////////
// Frame bit counts
`define FWE_OPCODE_BITS       6'h08
`define FWE_FRAME_BITS        6'h20
`define FWE_FRAME_WRAP        6'h27

////////////////////////////////////////////////////////////////////////////////
// Page walk and reset values
`define FWE_LAST_BYTE         8'hff
`define FWE_RST_LATCH         1'h0
`define FWE_RST_BUSY          1'h0
`define FWE_RST_ERROR         1'h0

`endif

// >>> core/fwe_pkg.sv
// Types shared by the command slice and its page program engine.
// Assumes fwe_defines.svh is on the include path.
package fwe_pkg;

  typedef logic [15:0] fwe_page_t;

  typedef enum logic [2:0]
  {
    FWE_ENG_IDLE = 3'h1,
    FWE_ENG_REQ  = 3'h2,
    FWE_ENG_WAIT = 3'h4
  } fwe_eng_state_t;

endpackage

// >>> core/fwe_prog_if.sv
// Start and status link between the command decoder and the page engine.
// Assumes both ends on REF_CLK.
interface fwe_prog_if;
  import fwe_pkg::*;

  logic      start;
  fwe_page_t page;
  logic      busy;
  logic      error;

  modport ctrl (output start, output page, input busy, input error);
  modport eng  (input start, input page, output busy, output error);
endinterface

// >>> core/fwe_prog_engine.sv
// Page program engine: walks all buffer bytes into the selected page.
// Assumes the array logic answers each request with one ack cycle and fail flag.
module fwe_prog_engine
  import fwe_pkg::*;
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // Command side
  fwe_prog_if.eng    prog,
  // Array side
  output logic [23:0] array_addr,
  output logic        array_req,
  input  wire logic   array_ack,
  input  wire logic   array_fail
);
  `include "fwe_defines.svh"

  fwe_eng_state_t state_q, state_d;
  logic [7:0]     idx_q, idx_d;
  fwe_page_t      page_q, page_d;
  logic           busy_q, busy_d;
  logic           err_q, err_d;
  logic           req_q, req_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    state_d = state_q;
    idx_d   = idx_q;
    page_d  = page_q;
    busy_d  = busy_q;
    err_d   = err_q;
    req_d   = req_q;
    unique case (state_q)
      FWE_ENG_IDLE:
      begin
        if (prog.start)
        begin
          page_d  = prog.page;
          idx_d   = 8'h00;
          busy_d  = 1'b1;
          err_d   = 1'b0;
          state_d = FWE_ENG_REQ;
        end
      end
      FWE_ENG_REQ:
      begin
        req_d   = 1'b1;
        state_d = FWE_ENG_WAIT;
      end
      FWE_ENG_WAIT:
      begin
        if (array_ack)
        begin
          req_d = 1'b0;
          if (array_fail)
            err_d = 1'b1;
          if (idx_q == `FWE_LAST_BYTE)
          begin
            busy_d  = 1'b0;
            state_d = FWE_ENG_IDLE;
          end
          else
          begin
            idx_d   = idx_q + 8'h01;
            state_d = FWE_ENG_REQ;
          end
        end
      end
      default:
      begin
        state_d = FWE_ENG_IDLE;
        busy_d  = 1'b0;
        req_d   = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= FWE_ENG_IDLE;
      idx_q   <= 8'h00;
      page_q  <= 16'h0000;
      busy_q  <= `FWE_RST_BUSY;
      err_q   <= `FWE_RST_ERROR;
      req_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      idx_q   <= idx_d;
      page_q  <= page_d;
      busy_q  <= busy_d;
      err_q   <= err_d;
      req_q   <= req_d;
    end
  end

  assign prog.busy  = busy_q;
  assign prog.error = err_q;
  assign array_req  = req_q;
  assign array_addr = {page_q, idx_q};
endmodule

// >>> core/fwe_top.sv
// Serial command slice: write enable latch, volatile arm and buffer program.
// Assumes a three-wire serial host, mode 0 sampling, and outside protection logic.

////////////////////////////////////////////////////////////////////////////////
module fwe_top
  import fwe_pkg::*;
(
  // Clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RESET,
  // Serial link
  input  wire logic       CS_N,
  input  wire logic       SCK,
  input  wire logic       SI,
  // Protection and array
  input  wire logic       PAGE_PROTECTED,
  output fwe_pkg::fwe_page_t TARGET_PAGE,
  output logic [23:0]     ARRAY_ADDR,
  output logic            ARRAY_REQ,
  input  wire logic       ARRAY_ACK,
  input  wire logic       ARRAY_FAIL,
  // Status
  output logic            WRITE_ENABLE_LATCH,
  output logic            READY_BUSY_FLAG,
  output logic            PROGRAM_ERROR_FLAG,
  output logic            VOLATILE_WRITE_ARMED,
  output logic            WRITE_ALLOWED
);
  `include "fwe_defines.svh"

  fwe_prog_if prog ();

  logic [2:0]  sync1_q, sync1_d;
  logic [2:0]  sync2_q, sync2_d;
  logic        sck_prev_q, sck_prev_d;
  logic        cs_prev_q, cs_prev_d;
  logic        cs_s, sck_s, si_s, sck_rise, cs_rise;

  logic [5:0]  bit_cnt_q, bit_cnt_d;
  logic [7:0]  opcode_q, opcode_d;
  logic [23:0] addr_q, addr_d;
  logic        aligned, has_opcode, has_addr;

  logic        wel_q, wel_d;
  logic        varm_q, varm_d;
  logic        start_q, start_d;
  logic        prog_ok;
  logic        take_cmd;

  function automatic logic is_op(input logic [7:0] op, input logic [7:0] ref_op);
    is_op = (op == ref_op);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge finding
  always_comb
  begin
    sync1_d    = {SI, SCK, CS_N};
    sync2_d    = sync1_q;
    sck_prev_d = sync2_q[1];
    cs_prev_d  = sync2_q[0];
  end

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      sync1_q    <= 3'h1;
      sync2_q    <= 3'h1;
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end
    else
    begin
      sync1_q    <= sync1_d;
      sync2_q    <= sync2_d;
      sck_prev_q <= sck_prev_d;
      cs_prev_q  <= cs_prev_d;
    end
  end

  assign cs_s     = sync2_q[0];
  assign sck_s    = sync2_q[1];
  assign si_s     = sync2_q[2];
  assign sck_rise = sck_s & ~sck_prev_q & ~cs_s;
  assign cs_rise  = cs_s & ~cs_prev_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame decode
  assign aligned    = (bit_cnt_q[2:0] == 3'h0);
  assign has_opcode = (bit_cnt_q >= `FWE_OPCODE_BITS);
  assign has_addr   = (bit_cnt_q >= `FWE_FRAME_BITS);
  assign prog_ok    = has_addr && !PAGE_PROTECTED;
  assign take_cmd   = cs_rise && aligned && has_opcode && !prog.busy;

  ////////////////////////////////////////////////////////////////////////////////
  // Shift and bit count
  always_comb
  begin
    bit_cnt_d = bit_cnt_q;
    opcode_d  = opcode_q;
    addr_d    = addr_q;
    if (cs_s)
      bit_cnt_d = 6'h00;
    else if (sck_rise)
    begin
      if (bit_cnt_q < `FWE_OPCODE_BITS)
        opcode_d = {opcode_q[6:0], si_s};
      else if (bit_cnt_q < `FWE_FRAME_BITS)
        addr_d = {addr_q[22:0], si_s};
      if (bit_cnt_q == `FWE_FRAME_WRAP)
        bit_cnt_d = `FWE_FRAME_BITS;
      else
        bit_cnt_d = bit_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      bit_cnt_q <= 6'h00;
      opcode_q  <= 8'h00;
      addr_q    <= 24'h000000;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_d;
      opcode_q  <= opcode_d;
      addr_q    <= addr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode
  always_comb
  begin
    wel_d   = wel_q;
    varm_d  = varm_q;
    start_d = 1'b0;
    if (take_cmd)
    begin
      if (is_op(opcode_q, `FWE_OP_WRITE_ENABLE))
        wel_d = 1'b1;
      else if (is_op(opcode_q, `FWE_OP_WRITE_DISABLE))
        wel_d = 1'b0;
      else if (is_op(opcode_q, `FWE_OP_VOLATILE_EN))
        varm_d = 1'b1;
      else if (is_op(opcode_q, `FWE_OP_STATUS_WRITE))
        varm_d = 1'b0;
      else if (is_op(opcode_q, `FWE_OP_BUFFER_PROGRAM) && wel_q)
      begin
        wel_d = 1'b0;
        if (prog_ok)
          start_d = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      wel_q   <= `FWE_RST_LATCH;
      varm_q  <= 1'b0;
      start_q <= 1'b0;
    end
    else
    begin
      wel_q   <= wel_d;
      varm_q  <= varm_d;
      start_q <= start_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Engine handshake
  assign prog.start = start_q;
  assign prog.page  = addr_q[23:8];

  ////////////////////////////////////////////////////////////////////////////////
  // Page engine
  fwe_prog_engine u_engine
  (
    .clk        (REF_CLK),
    .rst        (RESET),
    .prog       (prog),
    .array_addr (ARRAY_ADDR),
    .array_req  (ARRAY_REQ),
    .array_ack  (ARRAY_ACK),
    .array_fail (ARRAY_FAIL)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Status outputs
  assign TARGET_PAGE          = addr_q[23:8];
  assign WRITE_ENABLE_LATCH   = wel_q;
  assign WRITE_ALLOWED        = wel_q;
  assign READY_BUSY_FLAG      = prog.busy;
  assign PROGRAM_ERROR_FLAG   = prog.error;
  assign VOLATILE_WRITE_ARMED = varm_q;
endmodule

// >>> testbench/fwe_top_sva.sv
// Checker for the command slice outputs.
// Assumes binding to fwe_top ports.
module fwe_top_chk
  import fwe_pkg::*;
(
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        RESET,
  // Watched
  input wire logic        CS_N,
  input wire logic        ARRAY_REQ,
  input wire logic        ARRAY_ACK,
  input wire logic [23:0] ARRAY_ADDR,
  input wire logic        READY_BUSY_FLAG,
  input wire logic        WRITE_ENABLE_LATCH
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  sequence s_ack;
    ARRAY_REQ && ARRAY_ACK;
  endsequence
  a_req_drops: assert property (s_ack |=> !ARRAY_REQ)
    else $error("request held after ack");
  a_next_index: assert property ((s_ack and ARRAY_ADDR[7:0] != 8'hff) |=> ##1
    (ARRAY_REQ && ARRAY_ADDR == $past(ARRAY_ADDR, 2) + 24'h000001)) else $error("bad next byte");
  a_busy_ends: assert property ((s_ack and ARRAY_ADDR[7:0] == 8'hff) |=> !READY_BUSY_FLAG)
    else $error("busy after last byte");
  a_req_busy: assert property (ARRAY_REQ |-> READY_BUSY_FLAG)
    else $error("request while ready");
  a_req_hold: assert property ((ARRAY_REQ && !ARRAY_ACK) |=> (ARRAY_REQ && $stable(ARRAY_ADDR)))
    else $error("request not held");
  a_latch_clear: assert property ($rose(READY_BUSY_FLAG) |-> !WRITE_ENABLE_LATCH)
    else $error("latch set while programming");
  a_page_start: assert property ($rose(READY_BUSY_FLAG) |=> (ARRAY_REQ && ARRAY_ADDR[7:0] == 8'h00))
    else $error("program not from page start");
  a_latch_cs: assert property ($changed(WRITE_ENABLE_LATCH) |-> $past(CS_N, 2))
    else $error("latch moved while selected");
endmodule
bind fwe_top fwe_top_chk u_chk (.REF_CLK(REF_CLK), .RESET(RESET), .CS_N(CS_N), .ARRAY_REQ(ARRAY_REQ),
  .ARRAY_ACK(ARRAY_ACK), .ARRAY_ADDR(ARRAY_ADDR), .READY_BUSY_FLAG(READY_BUSY_FLAG),
  .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH));

// >>> testbench/fwe_host.sv
// Host serial controller model, mode 0, 200 ns link clock.
// Assumes the caller waits for any program to end.
module fwe_host
(
  output logic cs_n,
  output logic sck,
  output logic si
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // Opcode then address, MSB first
  task automatic frame(input logic [39:0] v, input int n);
    cs_n = 1'b0;
    #100;
    for (int i = 0; i < n; i++)
    begin
      si = v[39-i];
      #100 sck = 1'b1;
      #100 sck = 1'b0;
    end
    #100 cs_n = 1'b1;
    si = ~si;
    #400;
  endtask
endmodule

// >>> testbench/fwe_top_tb.sv
// Self-checking bench for the command slice.
// Assumes the host model and a random-stall array responder.
module fwe_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fwe_pkg::*;
  logic        ref_clk, reset, prot, ack, fail, cs_n, sck, si, req, write_enable_latch, rdy, err, arm, allow;
  logic [23:0] addr;
  fwe_page_t   page, m_page;
  int          n_errors, total_checks, cyc, n_acks, fail_idx, m_wel, m_arm, m_busy, m_err;
  fwe_host h (.cs_n(cs_n), .sck(sck), .si(si));
  fwe_top DUT (.REF_CLK(ref_clk), .RESET(reset), .CS_N(cs_n), .SCK(sck), .SI(si), .PAGE_PROTECTED(prot),
    .TARGET_PAGE(page), .ARRAY_ADDR(addr), .ARRAY_REQ(req), .ARRAY_ACK(ack), .ARRAY_FAIL(fail),
    .WRITE_ENABLE_LATCH(write_enable_latch), .READY_BUSY_FLAG(rdy), .PROGRAM_ERROR_FLAG(err),
    .VOLATILE_WRITE_ARMED(arm), .WRITE_ALLOWED(allow));
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Model update, frame, then compare
  task automatic send(input logic [7:0] op, input logic [23:0] a, input int n);
    if (n % 8 == 0)
      case (op)
        8'h06: m_wel = 1;
        8'h04: m_wel = 0;
        8'h50: m_arm = 1;
        8'h01: m_arm = 0;
        8'h88:
        begin
          if (m_wel != 0 && n >= 32 && !prot)
          begin
            m_busy = 1;
            m_err = 0;
            n_acks = 0;
            m_page = a[23:8];
          end
          m_wel = 0;
        end
        default: ;
      endcase
    h.frame({op, a, 8'h00}, n);
    chk("latch", write_enable_latch, m_wel);
    chk("arm", arm, m_arm);
    chk("allow", allow, m_wel);
    chk("busy", rdy, m_busy);
    if (m_busy != 0)
    begin
      chk("page", page, m_page);
      for (int i = 0; i < 3000 && rdy; i++)
        @(negedge ref_clk);
      @(negedge ref_clk);
      m_busy = 0;
      chk("ready", rdy, m_busy);
      chk("acks", n_acks, 256);
      chk("error", err, m_err);
    end
  endtask
  // Array responder with random stalls
  always @(negedge ref_clk)
  begin
    ack <= req && !ack && ($urandom % 3 != 0);
    fail <= (fail_idx == addr[7:0]);
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc > 60000)
    begin
      n_errors++;
      give_verdict;
    end
    if (req && ack)
    begin
      chk("addr", addr, {m_page, n_acks[7:0]});
      n_acks++;
      if (fail)
        m_err = 1;
    end
  end
  initial
  begin
    reset = 1'b1;
    prot = 1'b0;
    fail_idx = 999;
    void'($urandom(32'h7ac7));
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("reset", {write_enable_latch, rdy, err, arm, allow}, 24'h000000);
    send(8'h88, 24'h012300, 32);
    send(8'h06, 24'h000000, 16);
    send(8'h04, 24'h000000, 7);
    send(8'h04, 24'h000000, 8);
    send(8'h50, 24'h000000, 8);
    send(8'h01, 24'h000000, 8);
    send(8'h06, 24'h000000, 8);
    send(8'h88, $urandom, 24);
    send(8'h06, 24'h000000, 8);
    @(negedge ref_clk) prot = 1'b1;
    send(8'h88, $urandom, 32);
    @(negedge ref_clk) prot = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      fail_idx = k ? 999 : $urandom % 256;
      send(8'h06, 24'h000000, 8);
      send(8'h88, $urandom, 32 + 8 * k);
    end
    give_verdict;
  end
endmodule
